// ---- ssbd_pkg.sv ----
// Functional notes
// (RULE1) Position mode: lit while error within window
// (RULE2) Rotation segment lit while speed above threshold
// (RULE3) Speed mode: lit while command above threshold
// (RULE4) Position mode: lit while command pulses arrive
// (RULE5) Torque mode: lit above fraction of rated
// (RULE6) Position mode: lit while clear input asserted
// (RULE7) Command noise flashes the minus segment
// (RULE8) Bus mode: group A shows port A
// (RULE9) Bus mode: group B shows port B
// (RULE10) Speed match lit in window; torque always
// (RULE11) Base-block segment lit while servo off
// (RULE12) Mode picks sources; compare each refresh
package ssbd_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] A_CTRL    = 8'h00; // Mode and units
	localparam logic [7:0] A_POS_WIN = 8'h04; // Position window
	localparam logic [7:0] A_ROT     = 8'h08; // Rotation thr, rotary
	localparam logic [7:0] A_LROT    = 8'h0C; // Rotation thr, linear
	localparam logic [7:0] A_MATCH   = 8'h10; // Match window, rotary
	localparam logic [7:0] A_LMATCH  = 8'h14; // Match window, linear
	localparam logic [7:0] A_TRQ_PCT = 8'h18; // Torque fraction, %
	localparam logic [7:0] A_RATED   = 8'h1C; // Rated torque
	localparam logic [7:0] A_SEG     = 8'h20; // Segment state, RO
	localparam logic [7:0] A_STAT    = 8'h24; // Sticky events, W1C
	localparam logic [7:0] A_MASK    = 8'h28; // Interrupt mask
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] R_POS_WIN = 32'h7;   // 7 command units
	localparam logic [31:0] R_ROT     = 32'h14;  // 20 per minute
	localparam logic [31:0] R_MATCH   = 32'hA;   // 10 per minute
	localparam logic [31:0] R_TRQ_PCT = 32'hA;   // Ten percent
	localparam logic [31:0] R_RATED   = 32'h3E8; // Neutral rated value
	localparam logic [31:0] PCT_FULL  = 32'h64;  // One hundred percent
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_LIN = 2; // Linear motor units
	localparam int SEG_BASE = 0; // Base block
	localparam int SEG_MTCH = 1; // Done or speed match
	localparam int SEG_ROT  = 2; // Rotation detect
	localparam int SEG_CMD  = 3; // Command present
	localparam int SEG_CLR  = 4; // Clear input
	localparam int EV_NOISE = 0; // Noise seen
	localparam int EV_DONE  = 1; // Positioning done rose
	localparam int EV_ROT   = 2; // Rotation detect rose
	localparam int EV_CLR   = 3; // Clear input rose
	localparam int EV_W     = 4; // Event count
	localparam int GRP_W    = 8; // Segments per group
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_KHZ    = 20000; // 20 MHz
	localparam int REFRESH_US = 1000;  // Display refresh
	localparam int FLASH_MS   = 250;   // Minus flash half period
	localparam int REFRESH_CYC = (REFRESH_US * CLK_KHZ) / 1000;
	localparam int FLASH_REFR  = (FLASH_MS * 1000) / REFRESH_US;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SSBD_SPEED = 2'b00,
		SSBD_POS   = 2'b01,
		SSBD_TRQ   = 2'b11,
		SSBD_BUS   = 2'b10
	} ssbd_mode_e;
	typedef struct packed {
		logic [GRP_W-1:0] grp_a; // Indicator group
		logic [GRP_W-1:0] grp_b; // Second group
		logic             minus; // Upper-left minus
	} ssbd_seg_s;
endpackage : ssbd_pkg

// ---- ssbd_display.sv ----
`timescale 1ns/1ps
module ssbd_display #(
	parameter int POS_W   = 24,
	parameter int SPD_W   = 16,
	parameter int REFRESH = ssbd_pkg::REFRESH_CYC,
	parameter int FLASH   = ssbd_pkg::FLASH_REFR
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     srst,
	// Register port
	input  wire logic [7:0]               addr,
	input  wire logic [31:0]              wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [31:0]              rdata,
	// Servo conditions
	input  wire logic signed [POS_W-1:0]  pos_err,
	input  wire logic signed [SPD_W-1:0]  speed,
	input  wire logic signed [SPD_W-1:0]  speed_cmd,
	input  wire logic signed [SPD_W-1:0]  torque_cmd,
	input  wire logic                     cmd_pulse,
	input  wire logic                     clear_in,
	input  wire logic                     noise_det,
	input  wire logic                     servo_on,
	// Bus connector inputs
	input  wire logic [ssbd_pkg::GRP_W-1:0] bus_port_a_inputs,
	input  wire logic [ssbd_pkg::GRP_W-1:0] bus_port_b_inputs,
	// Display and interrupt
	output ssbd_pkg::ssbd_seg_s           seg,
	output logic                          irq
);
	import ssbd_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Magnitude of a signed quantity
	function automatic logic [POS_W-1:0] mag(
		input logic signed [POS_W-1:0] v
	);
		mag = v[POS_W-1] ? POS_W'(-v) : v;
	endfunction : mag

	// Widen a speed-size value for mag
	function automatic logic signed [POS_W-1:0] wid(
		input logic signed [SPD_W-1:0] v
	);
		wid = POS_W'(v);
	endfunction : wid

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0]        mode_ff;     // Control mode
	logic              lin_ff;      // Linear units
	logic [31:0]       pos_win_ff;  // Position window
	logic [31:0]       rot_ff;      // Rotary threshold
	logic [31:0]       lrot_ff;     // Linear threshold
	logic [31:0]       match_ff;    // Rotary match window
	logic [31:0]       lmatch_ff;   // Linear match window
	logic [31:0]       pct_ff;      // Torque percent
	logic [31:0]       rated_ff;    // Rated torque
	logic [EV_W-1:0]   stat_ff;     // Sticky events
	logic [EV_W-1:0]   mask_ff;     // Interrupt mask
	logic [31:0]       rdata_ff;    // Read data

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire w_ctrl  = wr && (addr == A_CTRL);
	wire w_posw  = wr && (addr == A_POS_WIN);
	wire w_rot   = wr && (addr == A_ROT);
	wire w_lrot  = wr && (addr == A_LROT);
	wire w_mtch  = wr && (addr == A_MATCH);
	wire w_lmtch = wr && (addr == A_LMATCH);
	wire w_pct   = wr && (addr == A_TRQ_PCT);
	wire w_rated = wr && (addr == A_RATED);
	wire w_stat  = wr && (addr == A_STAT);
	wire w_mask  = wr && (addr == A_MASK);

	// ----------------------------------------
	// Refresh and flash timing
	// ----------------------------------------
	logic [31:0] ref_cnt_ff;   // Cycles in refresh period
	logic [31:0] flash_cnt_ff; // Refreshes in half flash
	logic        blink_ff;     // Flash phase

	// One-cycle tick at end of each refresh period
	wire tick = (ref_cnt_ff == 32'(REFRESH - 1));
	wire flip = tick && (flash_cnt_ff == 32'(FLASH - 1));

	// Refresh counter free-runs
	always_ff @(posedge clock) begin
		if (srst || tick) begin
			ref_cnt_ff <= '0;
		end else begin
			ref_cnt_ff <= ref_cnt_ff + 32'h1;
		end
	end

	// Flash counter counts refreshes
	always_ff @(posedge clock) begin
		if (srst || flip) begin
			flash_cnt_ff <= '0;
		end else if (tick) begin
			flash_cnt_ff <= flash_cnt_ff + 32'h1;
		end
	end

	// Flash phase toggles each half period
	always_ff @(posedge clock) begin
		if (srst) begin
			blink_ff <= 1'b0;
		end else if (flip) begin
			blink_ff <= ~blink_ff;
		end
	end

	// ----------------------------------------
	// Per-period event capture
	// ----------------------------------------
	// Pulses and noise are brief, so they are held
	// over a whole refresh period to stay visible.
	logic pulse_acc_ff; // Pulse seen this period
	logic noise_acc_ff; // Noise seen this period

	always_ff @(posedge clock) begin
		if (srst || tick) begin
			pulse_acc_ff <= 1'b0;
			noise_acc_ff <= 1'b0;
		end else begin
			pulse_acc_ff <= pulse_acc_ff | cmd_pulse;
			noise_acc_ff <= noise_acc_ff | noise_det;
		end
	end

	// ----------------------------------------
	// Threshold comparisons
	// ----------------------------------------
	// Unit set chosen by linear bit
	wire [31:0] thr_rot = lin_ff ? lrot_ff : rot_ff;
	wire [31:0] thr_mch = lin_ff ? lmatch_ff : match_ff;

	wire [POS_W-1:0] spd_m  = mag(wid(speed));
	wire [POS_W-1:0] cmd_m  = mag(wid(speed_cmd));
	wire [POS_W-1:0] trq_m  = mag(wid(torque_cmd));
	wire [POS_W-1:0] err_m  = mag(pos_err);
	wire [POS_W-1:0] serr_m = mag(wid(speed) - wid(speed_cmd));

	// Torque checked as trq*100 > pct*rated
	wire [63:0] trq_l = 64'(trq_m) * 64'(PCT_FULL);
	wire [63:0] trq_r = 64'(pct_ff) * 64'(rated_ff);

	wire c_done = 32'(err_m) <= pos_win_ff;  // [RULE1]
	wire c_rot  = 32'(spd_m) > thr_rot;      // [RULE2]
	wire c_scmd = 32'(cmd_m) > thr_rot;      // [RULE3]
	wire c_trq  = trq_l > trq_r;             // [RULE5]
	wire c_mtch = 32'(serr_m) <= thr_mch;    // [RULE10]

	// ----------------------------------------
	// Refresh-sampled conditions
	// ----------------------------------------
	logic done_ff;  // Positioning done
	logic rot_s_ff; // Rotating
	logic scmd_ff;  // Speed command present
	logic trq_s_ff; // Torque command present
	logic mtch_ff;  // Speed matched
	logic pls_ff;   // Pulses during last period
	logic clr_s_ff; // Clear asserted
	logic nse_ff;   // Noise during last period
	logic bb_ff;    // Servo off

	// All comparisons refreshed once per period
	always_ff @(posedge clock) begin
		if (srst) begin
			done_ff  <= 1'b0;
			rot_s_ff <= 1'b0;
			scmd_ff  <= 1'b0;
			trq_s_ff <= 1'b0;
			mtch_ff  <= 1'b0;
			pls_ff   <= 1'b0;
			clr_s_ff <= 1'b0;
			nse_ff   <= 1'b0;
			bb_ff    <= 1'b1;
		end else if (tick) begin // [RULE12]
			done_ff  <= c_done;
			rot_s_ff <= c_rot;
			scmd_ff  <= c_scmd;
			trq_s_ff <= c_trq;
			mtch_ff  <= c_mtch;
			pls_ff   <= pulse_acc_ff | cmd_pulse; // [RULE4]
			clr_s_ff <= clear_in;                 // [RULE6]
			nse_ff   <= noise_acc_ff | noise_det; // [RULE7]
			bb_ff    <= ~servo_on;                // [RULE11]
		end
	end

	// ----------------------------------------
	// Mode selection of shared segments
	// ----------------------------------------
	logic [GRP_W-1:0] ind; // Indicator group by mode

	// Mode decides what each segment means
	always_comb begin
		ind = '0;
		ind[SEG_BASE] = bb_ff;            // [RULE11]
		ind[SEG_ROT]  = rot_s_ff;         // [RULE2]
		case (ssbd_mode_e'(mode_ff))
			SSBD_SPEED: begin
				ind[SEG_MTCH] = mtch_ff;    // [RULE10]
				ind[SEG_CMD]  = scmd_ff;    // [RULE3]
			end
			SSBD_POS: begin
				ind[SEG_MTCH] = done_ff;    // [RULE1]
				ind[SEG_CMD]  = pls_ff;     // [RULE4]
				ind[SEG_CLR]  = clr_s_ff;   // [RULE6]
			end
			SSBD_TRQ: begin
				ind[SEG_MTCH] = 1'b1;       // [RULE10]
				ind[SEG_CMD]  = trq_s_ff;   // [RULE5]
			end
			default: begin
				ind = '0;                   // Bus mode
			end
		endcase
	end

	wire is_bus = (ssbd_mode_e'(mode_ff) == SSBD_BUS);

	// Next display image
	wire [GRP_W-1:0] nxt_a = is_bus ? bus_port_a_inputs : ind;
	wire [GRP_W-1:0] nxt_b = is_bus ? bus_port_b_inputs : '0;

	// Display image registered for clean outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			seg <= '0;
		end else begin
			seg.grp_a <= nxt_a;             // [RULE8]
			seg.grp_b <= nxt_b;             // [RULE9]
			seg.minus <= nse_ff & blink_ff; // [RULE7]
		end
	end

	// ----------------------------------------
	// Event detection and interrupt
	// ----------------------------------------
	logic done_d_ff; // Previous done
	logic rot_d_ff;  // Previous rotation
	logic clr_d_ff;  // Previous clear

	always_ff @(posedge clock) begin
		if (srst) begin
			done_d_ff <= 1'b0;
			rot_d_ff  <= 1'b0;
			clr_d_ff  <= 1'b0;
		end else begin
			done_d_ff <= done_ff;
			rot_d_ff  <= rot_s_ff;
			clr_d_ff  <= clr_s_ff;
		end
	end

	logic [EV_W-1:0] ev; // Edge events last one cycle; noise is the raw level

	always_comb begin
		ev = '0;
		ev[EV_NOISE] = noise_det;
		ev[EV_DONE]  = done_ff & ~done_d_ff;
		ev[EV_ROT]   = rot_s_ff & ~rot_d_ff;
		ev[EV_CLR]   = clr_s_ff & ~clr_d_ff;
	end

	// Set wins over a same-cycle clear
	wire [EV_W-1:0] clr_w = w_stat ? wdata[EV_W-1:0] : '0;
	wire [EV_W-1:0] nxt_stat = (stat_ff & ~clr_w) | ev;

	always_ff @(posedge clock) begin
		if (srst) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	assign irq = |(stat_ff & mask_ff);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Control and mask
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_ff <= SSBD_SPEED;
			lin_ff  <= 1'b0;
			mask_ff <= '0;
		end else begin
			if (w_ctrl) begin
				mode_ff <= wdata[1:0];
				lin_ff  <= wdata[CTRL_LIN];
			end
			if (w_mask) begin
				mask_ff <= wdata[EV_W-1:0];
			end
		end
	end

	// Threshold parameters
	always_ff @(posedge clock) begin
		if (srst) begin
			pos_win_ff <= R_POS_WIN;
			rot_ff     <= R_ROT;
			lrot_ff    <= R_ROT;
			match_ff   <= R_MATCH;
			lmatch_ff  <= R_MATCH;
			pct_ff     <= R_TRQ_PCT;
			rated_ff   <= R_RATED;
		end else begin
			if (w_posw)  pos_win_ff <= wdata;
			if (w_rot)   rot_ff     <= wdata;
			if (w_lrot)  lrot_ff    <= wdata;
			if (w_mtch)  match_ff   <= wdata;
			if (w_lmtch) lmatch_ff  <= wdata;
			if (w_pct)   pct_ff     <= wdata;
			if (w_rated) rated_ff   <= wdata;
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	logic [31:0] nxt_rdata; // Read mux

	// Unmapped addresses read zero
	always_comb begin
		case (addr)
			A_CTRL:    nxt_rdata = {29'h0, lin_ff, mode_ff};
			A_POS_WIN: nxt_rdata = pos_win_ff;
			A_ROT:     nxt_rdata = rot_ff;
			A_LROT:    nxt_rdata = lrot_ff;
			A_MATCH:   nxt_rdata = match_ff;
			A_LMATCH:  nxt_rdata = lmatch_ff;
			A_TRQ_PCT: nxt_rdata = pct_ff;
			A_RATED:   nxt_rdata = rated_ff;
			A_SEG:     nxt_rdata = 32'(seg);
			A_STAT:    nxt_rdata = 32'(stat_ff);
			A_MASK:    nxt_rdata = 32'(mask_ff);
			default:   nxt_rdata = '0;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= rd ? nxt_rdata : '0;
		end
	end

	assign rdata = rdata_ff;
endmodule : ssbd_display

// ---- ssbd_checker_sva.sv ----
`timescale 1ns/1ps
module ssbd_checker #(
	parameter int SPD_W   = 16,
	parameter int REFRESH = ssbd_pkg::REFRESH_CYC
) (
	// Clock and reset
	input wire logic                       clock,
	input wire logic                       srst,
	// Register port
	input wire logic [7:0]                 addr,
	input wire logic [31:0]                wdata,
	input wire logic                       wr,
	input wire logic                       rd,
	input wire logic [31:0]                rdata,
	// Conditions and display
	input wire logic signed [SPD_W-1:0]    speed,
	input wire logic                       clear_in,
	input wire logic                       servo_on,
	input wire logic [ssbd_pkg::GRP_W-1:0] bus_port_a_inputs,
	input wire logic [ssbd_pkg::GRP_W-1:0] bus_port_b_inputs,
	input wire ssbd_pkg::ssbd_seg_s        seg,
	input wire logic                       irq
);
	import ssbd_pkg::*;
	// ----------------------------------------
	// Mirrors of mode, mask and refresh tick
	// ----------------------------------------
	logic [1:0]  mode_ff; // Mode as last written
	logic        lin_ff;  // Linear units as last written
	logic [31:0] rot_ff;  // Rotary threshold copy
	logic [31:0] lrot_ff; // Linear threshold copy
	logic [31:0] mask_ff; // Mask as last written
	logic [31:0] cnt_ff;  // Refresh counter copy
	logic [2:0]  calm_ff; // Cycles since reset or mode write
	wire         tick     = (cnt_ff == REFRESH - 1);
	wire         ctrl_wr  = wr && (addr == A_CTRL);
	wire         calm     = (calm_ff >= 3'h4);
	wire  [31:0] nxt_cnt  = tick ? 32'h0 : cnt_ff + 32'h1;
	wire  [2:0]  nxt_calm = ctrl_wr ? 3'h0 : ((calm_ff == 3'h7) ? calm_ff : calm_ff + 3'h1);
	// Rotation expectation follows the unit set in use
	wire signed [31:0] spd_x   = 32'(speed);                      // Sign-extended speed
	wire        [31:0] spd_mag = spd_x[31] ? 32'(-spd_x) : spd_x; // Speed magnitude
	wire        [31:0] thr_rot = lin_ff ? lrot_ff : rot_ff;       // Threshold in use
	wire               rot_exp = spd_mag > thr_rot;               // Rotation expected
	// Calm waits out the sample pipeline after a mode change
	always_ff @(posedge clock) begin
		if (srst) begin
			mode_ff <= 2'h0;
			lin_ff  <= 1'b0;
			rot_ff  <= R_ROT;
			lrot_ff <= R_ROT;
			mask_ff <= 32'h0;
			cnt_ff  <= 32'h0;
			calm_ff <= 3'h0;
		end else begin
			cnt_ff  <= nxt_cnt;
			calm_ff <= nxt_calm;
			if (ctrl_wr) begin
				mode_ff <= wdata[1:0];
				lin_ff  <= wdata[CTRL_LIN];
			end
			if (wr && (addr == A_ROT)) begin
				rot_ff <= wdata;
			end
			if (wr && (addr == A_LROT)) begin
				lrot_ff <= wdata;
			end
			if (wr && (addr == A_MASK)) begin
				mask_ff <= wdata;
			end
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_bus_grp_a: assert property (@(posedge clock) disable iff (srst)
		($past(mode_ff) == SSBD_BUS && !$past(srst)) |-> seg.grp_a == $past(bus_port_a_inputs))
		else $error("group A does not follow port A");
	a_bus_grp_b: assert property (@(posedge clock) disable iff (srst)
		($past(mode_ff) == SSBD_BUS && !$past(srst)) |-> seg.grp_b == $past(bus_port_b_inputs))
		else $error("group B does not follow port B");
	a_seg_hold: assert property (@(posedge clock) disable iff (srst)
		(calm && mode_ff != SSBD_BUS && !$past(tick) && !$past(tick, 2)) |-> $stable(seg))
		else $error("segments moved between refresh ticks");
	a_trq_match: assert property (@(posedge clock) disable iff (srst)
		(calm && mode_ff == SSBD_TRQ && $past(tick, 2)) |-> seg.grp_a[SEG_MTCH])
		else $error("match segment dark in torque mode");
	a_base_blk: assert property (@(posedge clock) disable iff (srst)
		(calm && mode_ff != SSBD_BUS && $past(tick, 2))
		|-> seg.grp_a[SEG_BASE] == !$past(servo_on, 2))
		else $error("base block segment wrong");
	a_clr_seg: assert property (@(posedge clock) disable iff (srst)
		(calm && mode_ff == SSBD_POS && $past(tick, 2)) |-> seg.grp_a[SEG_CLR] == $past(clear_in, 2))
		else $error("clear segment wrong");
	a_rot_seg: assert property (@(posedge clock) disable iff (srst)
		(calm && mode_ff != SSBD_BUS && $past(tick, 2))
		|-> seg.grp_a[SEG_ROT] == $past(rot_exp, 2))
		else $error("rotation segment wrong");
	a_rdata_idle: assert property (@(posedge clock) disable iff (srst)
		!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
	a_irq_masked: assert property (@(posedge clock) disable iff (srst)
		(mask_ff == 32'h0) |-> !irq)
		else $error("interrupt with all sources masked");
endmodule : ssbd_checker
bind ssbd_display ssbd_checker #(.SPD_W(SPD_W), .REFRESH(REFRESH)) i_ssbd_checker (
	.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .speed(speed), .clear_in(clear_in), .servo_on(servo_on),
	.bus_port_a_inputs(bus_port_a_inputs), .bus_port_b_inputs(bus_port_b_inputs),
	.seg(seg), .irq(irq)
);

// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("wrong value at %0t ns: %s", $time, msg); \
		end \
	end
module tb;
	import ssbd_pkg::*;
	// ----------------------------------------
	// Signals and settings
	// ----------------------------------------
	localparam int REF = 8; // Short refresh keeps the run brief
	localparam int FL  = 2; // Short flash count
	localparam logic [7:0]  RA [11] = '{A_CTRL, A_POS_WIN, A_ROT, A_LROT, A_MATCH, A_LMATCH,
		A_TRQ_PCT, A_RATED, A_STAT, A_MASK, 8'h30};
	localparam logic [31:0] RV [11] = '{32'h0, R_POS_WIN, R_ROT, R_ROT, R_MATCH, R_MATCH,
		R_TRQ_PCT, R_RATED, 32'h2, 32'h0, 32'h0}; // Zero error lies in the window: done rose
	logic               clock, srst, wr, rd;          // Clock, reset, strobes
	logic [7:0]         addr, port_a, port_b;         // Address, bus connectors
	logic [31:0]        wdata, rdata;                 // Register data
	logic signed [23:0] pos_err;                      // Position error
	logic signed [15:0] speed, speed_cmd, torque_cmd; // Servo values
	logic               cmd_pulse, pulse_en;          // Pulse train and its enable
	logic               clear_in, noise_det, servo_on, irq;
	ssbd_seg_s          seg;                          // Segment outputs
	int                 failures, check_count, hits;  // Tallies
	ssbd_display #(.REFRESH(REF), .FLASH(FL)) i_ssbd_display (
		.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pos_err(pos_err), .speed(speed), .speed_cmd(speed_cmd),
		.torque_cmd(torque_cmd), .cmd_pulse(cmd_pulse), .clear_in(clear_in),
		.noise_det(noise_det), .servo_on(servo_on), .bus_port_a_inputs(port_a),
		.bus_port_b_inputs(port_b), .seg(seg), .irq(irq)
	);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Pulse every other cycle while enabled
	always @(posedge clock) begin
		cmd_pulse <= pulse_en & ~cmd_pulse;
	end
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	// A gap cycle after each strobe keeps one assignment per time step
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr    <= 1'b0;
		@(posedge clock);
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd   <= 1'b0;
		#1;
		`CHK(rdata, e, m)
		@(posedge clock);
	endtask : rd_chk
	// Two refresh periods cover one full sample of the new inputs
	task automatic seg_bit(input int i, input logic e, input string m);
		repeat (2 * REF + 2) @(posedge clock);
		#1;
		`CHK(seg.grp_a[i], e, m)
		@(posedge clock);
	endtask : seg_bit
	task automatic irq_chk(input logic e);
		#1;
		`CHK(irq, e, "interrupt line")
		@(posedge clock);
	endtask : irq_chk
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{wr, rd, pulse_en, clear_in, noise_det, servo_on} = 6'h0;
		{addr, port_a, port_b, wdata} = 56'h0;
		{pos_err, speed, speed_cmd, torque_cmd} = 72'h0;
		failures = 0;
		check_count = 0;
		srst = 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		// Defaults, an unmapped place, a write to the read-only word
		wr_reg(8'h30, 32'hFFFFFFFF);
		wr_reg(A_SEG, 32'h0);
		for (int k = 0; k < 11; k++) begin
			rd_chk(RA[k], RV[k], "reset value");
		end
		$display("test defaults done");
		// Speed mode, thresholds at and beyond their edges
		seg_bit(SEG_BASE, 1'b1, "base block");
		speed <= 16'sh15;
		seg_bit(SEG_ROT, 1'b1, "rotation above");
		speed <= 16'sh14;
		seg_bit(SEG_ROT, 1'b0, "rotation at threshold");
		speed_cmd <= 16'sh15;
		seg_bit(SEG_CMD, 1'b1, "command above");
		seg_bit(SEG_MTCH, 1'b1, "speeds match");
		speed_cmd <= 16'sh14;
		speed <= -16'sh15;
		seg_bit(SEG_CMD, 1'b0, "command at threshold");
		seg_bit(SEG_MTCH, 1'b0, "speeds apart");
		seg_bit(SEG_ROT, 1'b1, "reverse rotation");
		speed <= 16'sh1E;
		seg_bit(SEG_MTCH, 1'b1, "match at window edge");
		servo_on <= 1'b1;
		seg_bit(SEG_BASE, 1'b0, "servo on");
		// Linear units pick their own threshold
		wr_reg(A_LROT, 32'h1E);
		wr_reg(A_CTRL, 32'h4);
		seg_bit(SEG_ROT, 1'b0, "linear threshold in use");
		rd_chk(A_LROT, 32'h1E, "linear threshold");
		$display("test speed mode done");
		// Position mode with clear event and interrupt
		wr_reg(A_CTRL, 32'h1);
		pos_err <= 24'sh7;
		seg_bit(SEG_MTCH, 1'b1, "error at window");
		pos_err <= -24'sh8;
		seg_bit(SEG_MTCH, 1'b0, "error beyond window");
		pulse_en <= 1'b1;
		seg_bit(SEG_CMD, 1'b1, "pulses arriving");
		pulse_en <= 1'b0;
		seg_bit(SEG_CMD, 1'b0, "pulses stopped");
		wr_reg(A_STAT, 32'hF);
		wr_reg(A_MASK, 32'h8);
		clear_in <= 1'b1;
		seg_bit(SEG_CLR, 1'b1, "clear asserted");
		rd_chk(A_STAT, 32'h8, "clear event");
		irq_chk(1'b1);
		wr_reg(A_STAT, 32'h8);
		irq_chk(1'b0);
		clear_in <= 1'b0;
		seg_bit(SEG_CLR, 1'b0, "clear released");
		wr_reg(A_MASK, 32'h0);
		$display("test position mode done");
		// Torque mode: one above and exactly at a tenth of rated
		wr_reg(A_CTRL, 32'h3);
		torque_cmd <= 16'sh65;
		seg_bit(SEG_CMD, 1'b1, "torque above tenth");
		seg_bit(SEG_MTCH, 1'b1, "match lit in torque");
		torque_cmd <= -16'sh64;
		seg_bit(SEG_CMD, 1'b0, "torque at tenth");
		$display("test torque mode done");
		// Bus mode: groups copy the connectors
		wr_reg(A_CTRL, 32'h2);
		for (int k = 0; k < 2; k++) begin
			port_a <= 8'hA5 ^ {8{k[0]}};
			port_b <= 8'h3C ^ {8{k[0]}};
			repeat (3) @(posedge clock);
			#1;
			`CHK(seg.grp_a, 8'hA5 ^ {8{k[0]}}, "port A group")
			`CHK(seg.grp_b, 8'h3C ^ {8{k[0]}}, "port B group")
			@(posedge clock);
		end
		rd_chk(A_SEG, {15'h0, 8'h5A, 8'hC3, 1'b0}, "segment word");
		$display("test bus mode done");
		// Noise flashes minus and raises the interrupt
		wr_reg(A_MASK, 32'h1);
		noise_det <= 1'b1;
		hits = 0;
		repeat (8 * REF * FL) begin
			@(posedge clock);
			#1;
			hits += int'(seg.minus);
		end
		`CHK(hits > 0 && hits < 8 * REF * FL, 1'b1, "minus not flashing")
		irq_chk(1'b1);
		noise_det <= 1'b0;
		wr_reg(A_STAT, 32'h1);
		irq_chk(1'b0);
		repeat (3 * REF) @(posedge clock);
		#1;
		`CHK(seg.minus, 1'b0, "minus after noise")
		$display("test noise done");
		wrap_up();
	end
	// Watchdog well beyond the expected run of about 600 cycles
	initial begin
		repeat (4000) @(posedge clock);
		failures++;
		wrap_up();
	end
endmodule : tb
